// file: core/pllsc_top.sv
// synthesizer control: register file, commit, calibration, fast lock, lock output
`timescale 1ns/1ns
`include "pllsc_consts.svh"
// Behaviour
// - calibration lasts (6+2^sel)*8+3 reference periods; sel 13 to 15 wrap the 16-bit length to 51
// - count select picks 15/3 or 31/7
// - lock select chooses raw or digital lock
// - digital lock rises/falls after thresholds
// - new frequency setup clears digital lock indication
// - unlock mute silences local when unlocked
// - fast lock enable bit gates fast lock
// - fast count is 511 plus field*512
// - tristate bit floats charge pump
// - modulator on bit forces modulator active
// - local mode selects local path
// - level field selects output power
// - freq words 2,3 pending until 1
// - write of word 1 copies words; if powered and mode not 3, commits, calibrates, times
// - fast current after calibration until expiry
// - calibration ties tuning, disables pump
module pllsc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_down_n,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [19:0] wr_data,
  input wire logic phase_small_err,
  input wire logic phase_raw,
  output logic lock_indicator,
  output logic [11:0] int_divide,
  output logic [1:0] vco_select,
  output logic [1:0] lo_divide,
  output logic [11:0] numerator_a,
  output logic [11:0] numerator_a_denominator,
  output logic [7:0] ref_divide,
  output logic [2:0] pump_current,
  output logic pump_tristate,
  output logic tune_to_ref,
  output logic modulator_on,
  output logic mixer_enable,
  output logic [1:0] local_mode,
  output logic [1:0] local_out_level,
  output logic local_out_en,
  output logic local_mute,
  output logic cal_busy,
  output logic fast_active
);
  logic pdn_s1_r;
  logic pdn_s2_r;
  logic err_s1_r;
  logic err_s2_r;
  logic raw_s1_r;
  logic raw_s2_r;
  logic [19:0] fraction_pump_current_pend_r;
  logic [19:0] ref_divide_denominator_pend_r;
  logic [19:0] integer_divide_vco_select_r;
  logic [19:0] fraction_pump_current_r;
  logic [19:0] ref_divide_denominator_r;
  logic [19:0] func_r;
  logic commit;
  logic [15:0] cal_cnt_r;
  logic [15:0] cal_len;
  logic [12:0] fast_cnt_r;
  logic [12:0] fast_len;
  pllsc_pkg::pllsc_state_t state_r;
  pllsc_lock_if lk ();

  // power_down_n, phase_small_err and phase_raw pass two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pdn_s1_r <= 1'b0;
      pdn_s2_r <= 1'b0;
      err_s1_r <= 1'b0;
      err_s2_r <= 1'b0;
      raw_s1_r <= 1'b0;
      raw_s2_r <= 1'b0;
    end else if (ce) begin
      pdn_s1_r <= power_down_n;
      pdn_s2_r <= pdn_s1_r;
      err_s1_r <= phase_small_err;
      err_s2_r <= err_s1_r;
      raw_s1_r <= phase_raw;
      raw_s2_r <= raw_s1_r;
    end
  end

  // commit only while the synthesizer is powered and local mode is not 3; otherwise the write just stores
  assign commit = wr_en && (wr_addr == `PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT) && pdn_s2_r &&
    (func_r[`PLLSC_F_MODE_LSB + 1 -: 2] != 2'h3);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fraction_pump_current_pend_r <= `PLLSC_REG_RESET;
      ref_divide_denominator_pend_r <= `PLLSC_REG_RESET;
      func_r <= `PLLSC_REG_RESET;
    end else if (ce && wr_en) begin
      if (wr_addr == `PLLSC_ADDR_FRACTION_PUMP_CURRENT) begin
        fraction_pump_current_pend_r <= wr_data;
      end
      if (wr_addr == `PLLSC_ADDR_REF_DIVIDE_DENOMINATOR) begin
        ref_divide_denominator_pend_r <= wr_data;
      end
      if (wr_addr == `PLLSC_ADDR_FUNC) begin
        func_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      integer_divide_vco_select_r <= `PLLSC_REG_RESET;
      fraction_pump_current_r <= `PLLSC_REG_RESET;
      ref_divide_denominator_r <= `PLLSC_REG_RESET;
    end else if (ce && wr_en && wr_addr == `PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT) begin
      integer_divide_vco_select_r <= wr_data;
      fraction_pump_current_r <= fraction_pump_current_pend_r;
      ref_divide_denominator_r <= ref_divide_denominator_pend_r;
    end
  end

  // lengths; cal selector limited to 4 bits so the shift fits 16 bits
  assign cal_len = ((`PLLSC_CAL_BASE + (16'h0001 << func_r[`PLLSC_F_CAL_TIME_SEL_LSB +: 4])) << `PLLSC_CAL_MUL)
    + `PLLSC_CAL_ADD;
  assign fast_len = `PLLSC_FAST_BASE + 13'(func_r[`PLLSC_F_FAST_LSB +: 4]) * `PLLSC_FAST_STEP;

  // sequencer: calibration, then fast lock if enabled; a new commit restarts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= pllsc_pkg::PLLSC_IDLE;
      cal_cnt_r <= 16'h0000;
      fast_cnt_r <= 13'h0000;
    end else if (ce) begin
      if (commit) begin
        state_r <= pllsc_pkg::PLLSC_CAL;
        cal_cnt_r <= cal_len - 16'h0001;
      end else begin
        case (state_r)
          pllsc_pkg::PLLSC_CAL: begin
            if (cal_cnt_r != 16'h0000) begin
              cal_cnt_r <= cal_cnt_r - 16'h0001;
            end else if (func_r[`PLLSC_F_FAST_LOCK_ENABLE]) begin
              state_r <= pllsc_pkg::PLLSC_FAST;
              fast_cnt_r <= fast_len;
            end else begin
              state_r <= pllsc_pkg::PLLSC_IDLE;
            end
          end
          pllsc_pkg::PLLSC_FAST: begin
            if (fast_cnt_r > 13'h0001) begin
              fast_cnt_r <= fast_cnt_r - 13'h0001;
            end else begin
              fast_cnt_r <= 13'h0000;
              state_r <= pllsc_pkg::PLLSC_IDLE;
            end
          end
          default: begin
            state_r <= pllsc_pkg::PLLSC_IDLE;
          end
        endcase
      end
    end
  end

  assign cal_busy = (state_r == pllsc_pkg::PLLSC_CAL);
  assign fast_active = (state_r == pllsc_pkg::PLLSC_FAST);

  assign lk.small_err = err_s2_r;
  assign lk.count_sel = func_r[`PLLSC_F_LDCNT];
  assign lk.restart = commit;

  pllsc_lock_det u_det (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .lk(lk)
  );

  // data outputs from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_indicator <= 1'b0;
      pump_current <= 3'h0;
      pump_tristate <= 1'b1;
      local_mute <= 1'b1;
    end else if (ce) begin
      lock_indicator <= func_r[`PLLSC_F_LDSEL] ? raw_s2_r : lk.locked;
      pump_current <= (state_r == pllsc_pkg::PLLSC_FAST) ? fraction_pump_current_r[14:12] : fraction_pump_current_r[18:16];
      pump_tristate <= func_r[`PLLSC_F_HIZ] || (state_r == pllsc_pkg::PLLSC_CAL);
      local_mute <= func_r[`PLLSC_F_MUTE] && !lk.locked;
    end
  end

  assign tune_to_ref = cal_busy;
  assign int_divide = integer_divide_vco_select_r[11:0];
  assign lo_divide = integer_divide_vco_select_r[14:13];
  assign vco_select = integer_divide_vco_select_r[16:15];
  assign numerator_a = fraction_pump_current_r[11:0];
  assign numerator_a_denominator = ref_divide_denominator_r[11:0];
  assign ref_divide = ref_divide_denominator_r[19:12];
  assign modulator_on = func_r[`PLLSC_F_DSM];
  assign mixer_enable = func_r[`PLLSC_F_MIXER_ENABLE];
  assign local_mode = func_r[`PLLSC_F_MODE_LSB +: 2];
  assign local_out_en = (local_mode == 2'h1);
  assign local_out_level = func_r[`PLLSC_F_LOCAL_OUT_LEVEL_LSB +: 2];

  // steps of the commit flow; the properties below are built from them
  sequence s_commit;
    ce && commit;
  endsequence
  sequence s_cal_step;
    ce && !commit && cal_busy && cal_cnt_r != 16'h0000;
  endsequence
  sequence s_cal_last;
    ce && !commit && cal_busy && cal_cnt_r == 16'h0000;
  endsequence
  sequence s_fast_step;
    ce && !commit && fast_active && fast_cnt_r > 13'h0001;
  endsequence
  sequence s_fast_last;
    ce && !commit && fast_active && fast_cnt_r <= 13'h0001;
  endsequence

  AST_CAL_LEN: assert property (@(posedge clock) disable iff (rst)
    (ce && commit && func_r[19:16] == 4'h1) |=> (cal_cnt_r == 16'h0042))
    else $error("calibration length wrong");
  AST_PEND: assert property (@(posedge clock) disable iff (rst)
    (ce && wr_en && wr_addr == `PLLSC_ADDR_FRACTION_PUMP_CURRENT) |=> $stable(fraction_pump_current_r))
    else $error("pending word leaked");
  AST_FAST_START: assert property (@(posedge clock) disable iff (rst)
    s_cal_last ##0 (func_r[`PLLSC_F_FAST_LOCK_ENABLE]) |=> (fast_active && fast_cnt_r == fast_len))
    else $error("fast timer not loaded");
  AST_NO_FAST: assert property (@(posedge clock) disable iff (rst)
    (!func_r[`PLLSC_F_FAST_LOCK_ENABLE] && !fast_active) |=> !fast_active)
    else $error("fast lock without enable");
  AST_PUMP_OFF: assert property (@(posedge clock) disable iff (rst)
    (ce && cal_busy) |=> pump_tristate)
    else $error("pump active in calibration");
  AST_COMMIT_UNLOCK: assert property (@(posedge clock) disable iff (rst)
    (ce && commit && !func_r[`PLLSC_F_LDSEL]) |=> ##1 !lock_indicator)
    else $error("lock survived setup");
  AST_COMMIT_CAL: assert property (@(posedge clock) disable iff (rst)
    s_commit |=> (cal_busy && tune_to_ref))
    else $error("commit did not start calibration");
  AST_CAL_STEP: assert property (@(posedge clock) disable iff (rst)
    s_cal_step |=> (cal_busy && cal_cnt_r == $past(cal_cnt_r) - 16'h0001))
    else $error("calibration count skipped");
  AST_CAL_DONE: assert property (@(posedge clock) disable iff (rst)
    s_cal_last ##0 (!func_r[`PLLSC_F_FAST_LOCK_ENABLE]) |=> (!cal_busy && !fast_active))
    else $error("calibration did not end");
  AST_FAST_STEP: assert property (@(posedge clock) disable iff (rst)
    s_fast_step |=> (fast_active && fast_cnt_r == $past(fast_cnt_r) - 13'h0001))
    else $error("fast timer skipped");
  AST_FAST_END: assert property (@(posedge clock) disable iff (rst)
    s_fast_last |=> !fast_active)
    else $error("fast lock outlived timer");
  AST_FAST_TOP: assert property (@(posedge clock) disable iff (rst)
    (func_r[`PLLSC_F_FAST_LSB +: 4] == 4'hF) |-> (fast_len == 13'h1FFF))
    else $error("fast count top wrong");
  // a word-1 write reloads the current fields, so those edges are left out
  AST_FAST_PUMP: assert property (@(posedge clock) disable iff (rst)
    (ce && fast_active && !(wr_en && wr_addr == `PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT))
    |=> (pump_current == fraction_pump_current_r[14:12]))
    else $error("fast pump current wrong");
  AST_NORM_PUMP: assert property (@(posedge clock) disable iff (rst)
    (ce && !fast_active && !(wr_en && wr_addr == `PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT))
    |=> (pump_current == fraction_pump_current_r[18:16]))
    else $error("normal pump current wrong");
  AST_HIZ_ON: assert property (@(posedge clock) disable iff (rst)
    (ce && func_r[`PLLSC_F_HIZ]) |=> pump_tristate)
    else $error("pump not floated");
  AST_HIZ_OFF: assert property (@(posedge clock) disable iff (rst)
    (ce && !func_r[`PLLSC_F_HIZ] && !cal_busy) |=> !pump_tristate)
    else $error("pump floated without cause");
  AST_LOCK_RAW: assert property (@(posedge clock) disable iff (rst)
    (ce && func_r[`PLLSC_F_LDSEL]) |=> (lock_indicator == $past(raw_s2_r)))
    else $error("raw lock not routed");
  AST_LOCK_DIG: assert property (@(posedge clock) disable iff (rst)
    (ce && !func_r[`PLLSC_F_LDSEL]) |=> (lock_indicator == $past(lk.locked)))
    else $error("digital lock not routed");
  AST_MUTE_ON: assert property (@(posedge clock) disable iff (rst)
    (ce && func_r[`PLLSC_F_MUTE] && !lk.locked) |=> local_mute)
    else $error("local not muted when unlocked");
  AST_MUTE_OFF: assert property (@(posedge clock) disable iff (rst)
    (ce && (!func_r[`PLLSC_F_MUTE] || lk.locked)) |=> !local_mute)
    else $error("local muted without cause");
  AST_COMMIT_COPY: assert property (@(posedge clock) disable iff (rst)
    (ce && wr_en && wr_addr == `PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT) |=> (int_divide == $past(wr_data[11:0]) &&
    numerator_a == $past(fraction_pump_current_pend_r[11:0]) && numerator_a_denominator == $past(ref_divide_denominator_pend_r[11:0])))
    else $error("committed words wrong");
  AST_REFUSE: assert property (@(posedge clock) disable iff (rst)
    (ce && wr_en && wr_addr == `PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT && !cal_busy && !fast_active &&
    (!pdn_s2_r || local_mode == 2'h3)) |=> !cal_busy)
    else $error("refused commit started calibration");
  // a low enable must hold the state, the counters and func_r
  AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
    !ce |=> ($stable(state_r) && $stable(cal_cnt_r) && $stable(fast_cnt_r) && $stable(func_r)))
    else $error("state moved with enable low");
endmodule : pllsc_top

// file: core/pllsc_consts.svh
// constants of the synthesizer control block: offsets, fields, counts
`ifndef PLLSC_CONSTS_SVH
`define PLLSC_CONSTS_SVH
`define PLLSC_ADDR_INTEGER_DIVIDE_VCO_SELECT 4'h1
`define PLLSC_ADDR_FRACTION_PUMP_CURRENT 4'h2
`define PLLSC_ADDR_REF_DIVIDE_DENOMINATOR 4'h3
`define PLLSC_ADDR_FUNC 4'h4
`define PLLSC_F_CAL_TIME_SEL_LSB 16
`define PLLSC_F_LDCNT 14
`define PLLSC_F_LDSEL 13
`define PLLSC_F_MUTE 12
`define PLLSC_F_FAST_LOCK_ENABLE 11
`define PLLSC_F_FAST_LSB 7
`define PLLSC_F_HIZ 6
`define PLLSC_F_DSM 5
`define PLLSC_F_MIXER_ENABLE 4
`define PLLSC_F_MODE_LSB 2
`define PLLSC_F_LOCAL_OUT_LEVEL_LSB 0
`define PLLSC_REG_RESET 20'h00000
`define PLLSC_LOCK_N0 5'h0F
`define PLLSC_UNLOCK_N0 5'h03
`define PLLSC_LOCK_N1 5'h1F
`define PLLSC_UNLOCK_N1 5'h07
`define PLLSC_FAST_BASE 13'h01FF
`define PLLSC_FAST_STEP 13'h0200
`define PLLSC_CAL_BASE 16'h0006
`define PLLSC_CAL_MUL 3
`define PLLSC_CAL_ADD 16'h0003
`endif

// file: core/pllsc_pkg.sv
// types of the synthesizer control block
package pllsc_pkg;
  typedef enum logic [1:0] {
    PLLSC_IDLE = 2'h0,
    PLLSC_CAL = 2'h1,
    PLLSC_FAST = 2'h3
  } pllsc_state_t;
endpackage : pllsc_pkg

// file: core/pllsc_lock_if.sv
// lock detector carrier between top and detector
`timescale 1ns/1ns
interface pllsc_lock_if;
  logic small_err;
  logic count_sel;
  logic restart;
  logic locked;
  modport top (output small_err, output count_sel, output restart, input locked);
  modport det (input small_err, input count_sel, input restart, output locked);
endinterface : pllsc_lock_if

// file: core/pllsc_lock_det.sv
// digital lock detector with consecutive-count thresholds
`timescale 1ns/1ns
`include "pllsc_consts.svh"
module pllsc_lock_det (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  pllsc_lock_if.det lk
);
  logic [4:0] run_r;
  logic locked_r;
  logic [4:0] need;
  always_comb begin
    if (locked_r) begin
      need = lk.count_sel ? `PLLSC_UNLOCK_N1 : `PLLSC_UNLOCK_N0;
    end else begin
      need = lk.count_sel ? `PLLSC_LOCK_N1 : `PLLSC_LOCK_N0;
    end
  end
  // count samples of the class that would flip the state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_r <= 5'h00;
      locked_r <= 1'b0;
    end else if (ce) begin
      if (lk.restart) begin
        run_r <= 5'h00;
        locked_r <= 1'b0;
      end else if (lk.small_err == locked_r) begin
        run_r <= 5'h00;
      end else if (run_r + 5'h01 >= need) begin
        run_r <= 5'h00;
        locked_r <= ~locked_r;
      end else begin
        run_r <= run_r + 5'h01;
      end
    end
  end
  assign lk.locked = locked_r;
  AST_LOCK_RISE: assert property (@(posedge clock) disable iff (rst)
    (ce && !lk.restart && !lk.count_sel && !locked_r && lk.small_err && run_r == 5'h0E) |=> locked_r)
    else $error("lock not declared at threshold");
  AST_LOCK_RUN: assert property (@(posedge clock) disable iff (rst)
    $rose(locked_r) |-> $past(lk.small_err))
    else $error("lock rose without small error");
  AST_RUN_RESTART: assert property (@(posedge clock) disable iff (rst)
    (ce && !lk.restart && lk.small_err == locked_r) |=> run_r == 5'h00)
    else $error("run counter not restarted");
endmodule : pllsc_lock_det

// file: sim/pllsc_host.sv
// host model: power-down pin and one-cycle control word writes
`timescale 1ns/1ns
module pllsc_host (
  input wire logic clock,
  output logic power_down_n,
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [19:0] wr_data
);
  initial begin
    power_down_n = 1'b0;
    wr_en = 1'b0;
    wr_addr = 4'h0;
    wr_data = 20'h00000;
  end
  task automatic write_word(input logic [3:0] a, input logic [19:0] d);
    @(posedge clock);
    #1;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clock);
    #1;
    wr_en = 1'b0;
    // idle bus shows the inverse so a stale word cannot pass for a fresh one
    wr_data = ~d;
  endtask : write_word
  task automatic set_power(input logic on);
    @(posedge clock);
    #1;
    power_down_n = on;
    // bias needs 500 us, 25000 cycles, before any commit
    if (on) repeat (25000) @(posedge clock);
  endtask : set_power
endmodule : pllsc_host

// file: sim/tb.sv
// self-checking bench of the synthesizer control block
`timescale 1ns/1ns
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic phase_small_err = 1'b0;
  logic phase_raw = 1'b0;
  logic power_down_n, wr_en, lock_indicator, pump_tristate, tune_to_ref, modulator_on;
  logic mixer_enable, local_out_en, local_mute, cal_busy, fast_active;
  logic [3:0] wr_addr;
  logic [19:0] wr_data;
  logic [11:0] int_divide, numerator_a, numerator_a_denominator;
  logic [7:0] ref_divide;
  logic [2:0] pump_current;
  logic [1:0] vco_select, lo_divide, local_mode, local_out_level;
  logic [4:0] snap;
  int bad_count = 0;
  int checks = 0;
  int n;
  always #10 clock = ~clock;
  pllsc_host pllsc_host_inst (.clock, .power_down_n, .wr_en, .wr_addr, .wr_data);
  pllsc_top pllsc_top_inst (.clock, .rst, .ce, .power_down_n, .wr_en, .wr_addr, .wr_data,
    .phase_small_err, .phase_raw, .lock_indicator, .int_divide, .vco_select, .lo_divide,
    .numerator_a, .numerator_a_denominator, .ref_divide, .pump_current, .pump_tristate, .tune_to_ref,
    .modulator_on, .mixer_enable, .local_mode, .local_out_level, .local_out_en, .local_mute,
    .cal_busy, .fast_active);
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  function automatic logic flag(input int s);
    return (s == 0) ? cal_busy : (s == 1) ? fast_active : lock_indicator;
  endfunction : flag
  task automatic wait_for(input int s, input logic lvl, input int lim);
    n = 0;
    while (flag(s) !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    if (flag(s) !== lvl) begin
      chk("wait bound", 20'h1, 20'h0);
      end_sim();
    end
  endtask : wait_for
  // length of a state, snapshot of the pump outputs two cycles in
  task automatic count_high(input int s);
    n = 0;
    while (flag(s) === 1'b1 && n < 20000) begin
      if (n == 2) snap = {tune_to_ref, pump_tristate, pump_current};
      cyc(1);
      n++;
    end
    if (n >= 20000) begin
      chk("count bound", 20'h1, 20'h0);
      end_sim();
    end
  endtask : count_high
  task automatic w(input logic [3:0] a, input logic [19:0] d);
    pllsc_host_inst.write_word(a, d);
  endtask : w
  initial begin
    cyc(3);
    rst = 1'b0;
    chk("tristate", 20'h1, pump_tristate);
    chk("mute", 20'h1, local_mute);
    pllsc_host_inst.set_power(1'b1);
    w(4'h4, 20'h11836);
    cyc(1);
    chk("dsm", 20'h1, modulator_on);
    chk("mix", 20'h1, mixer_enable);
    chk("mode", 20'h1, local_mode);
    chk("lo_en", 20'h1, local_out_en);
    chk("level", 20'h2, local_out_level);
    w(4'h5, 20'hFFFFF);
    cyc(2);
    chk("unmapped", 20'h1, local_mode);
    w(4'h2, 20'h53019);
    w(4'h3, 20'h010C0);
    cyc(2);
    chk("numerator_a held", 20'h0, numerator_a);
    chk("den held", 20'h0, numerator_a_denominator);
    w(4'h1, 20'h0A080);
    wait_for(0, 1'b1, 4);
    count_high(0);
    chk("cal len", 20'd67, 20'(n));
    chk("cal pump", 20'h3, snap[4:3]);
    chk("int", 20'd128, int_divide);
    chk("vco", 20'h1, vco_select);
    chk("div", 20'h1, lo_divide);
    chk("numerator_a", 20'd25, numerator_a);
    chk("den", 20'd192, numerator_a_denominator);
    chk("refdiv", 20'h1, ref_divide);
    wait_for(1, 1'b1, 3);
    count_high(1);
    chk("fast len", 20'd511, 20'(n));
    chk("fast cp", 20'h3, snap[2:0]);
    cyc(2);
    chk("norm cp", 20'h5, pump_current);
    chk("tristate", 20'h0, pump_tristate);
    phase_small_err = 1'b1;
    cyc(10);
    phase_small_err = 1'b0;
    cyc(1);
    phase_small_err = 1'b1;
    cyc(10);
    phase_small_err = 1'b0;
    cyc(4);
    chk("broken run", 20'h0, lock_indicator);
    phase_small_err = 1'b1;
    wait_for(2, 1'b1, 30);
    chk("lock 15", 20'h1, 20'(n >= 14 && n <= 20));
    cyc(2);
    chk("unmuted", 20'h0, local_mute);
    phase_small_err = 1'b0;
    wait_for(2, 1'b0, 12);
    chk("unlock 3", 20'h1, 20'(n >= 3 && n <= 8));
    cyc(2);
    chk("muted", 20'h1, local_mute);
    w(4'h4, 20'h15836);
    phase_small_err = 1'b1;
    wait_for(2, 1'b1, 45);
    chk("lock 31", 20'h1, 20'(n >= 30 && n <= 36));
    w(4'h1, 20'h0A080);
    cyc(1);
    chk("setup clear", 20'h0, lock_indicator);
    wait_for(0, 1'b0, 100);
    wait_for(1, 1'b0, 600);
    // raw lock select, mute off, fast lock off, pump floated
    w(4'h4, 20'h12050);
    phase_raw = 1'b1;
    cyc(5);
    chk("raw hi", 20'h1, lock_indicator);
    phase_raw = 1'b0;
    cyc(5);
    chk("raw lo", 20'h0, lock_indicator);
    chk("dsm off", 20'h0, modulator_on);
    chk("lo_en off", 20'h0, local_out_en);
    w(4'h1, 20'h0A080);
    wait_for(0, 1'b1, 4);
    // enable low must freeze the calibration count
    ce = 1'b0;
    cyc(100);
    chk("frozen cal", 20'h1, cal_busy);
    ce = 1'b1;
    wait_for(0, 1'b0, 100);
    cyc(2);
    chk("no fast", 20'h0, fast_active);
    chk("hiz", 20'h1, pump_tristate);
    // calibration select 11, the longest length that stays under the 20000-cycle count bound
    w(4'h4, 20'hB2050);
    w(4'h1, 20'h0A080);
    wait_for(0, 1'b1, 4);
    count_high(0);
    chk("cal len 11", 20'd16435, 20'(n));
    // external local mode refuses the commit
    w(4'h4, 20'hB205C);
    w(4'h1, 20'h0A080);
    cyc(4);
    chk("mode 3 ignored", 20'h0, cal_busy);
    chk("mode", 20'h3, local_mode);
    w(4'h4, 20'hB2050);
    pllsc_host_inst.set_power(1'b0);
    cyc(4);
    w(4'h1, 20'h0A080);
    cyc(4);
    chk("unpowered", 20'h0, cal_busy);
    rst = 1'b1;
    cyc(1);
    chk("reset int", 20'h0, int_divide);
    chk("reset mute", 20'h1, local_mute);
    rst = 1'b0;
    cyc(2);
    chk("after reset", 20'h0, lock_indicator);
    end_sim();
  end
endmodule : tb
